// ==== logic/ecp_edge_sync.v ====
// Synchroniser and falling-edge detector for the command inputs.
`timescale 1ns/1ps
`default_nettype none
module ecp_edge_sync #(
    parameter N = 7
) (
    // Clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    // Command pins and qualifier
    input  wire [N-1:0] cmd_n,
    input  wire         enable,
    // One-cycle pulses
    output wire [N-1:0] fall_pulse
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_bit
            reg s1_r;
            reg s2_r;
            reg s3_r;
            // Inputs idle high through pull-ups, so reset to one avoids a false edge.
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_r <= 1'b1;
                    s2_r <= 1'b1;
                    s3_r <= 1'b1;
                end
                else
                begin
                    s1_r <= cmd_n[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            assign fall_pulse[i] = enable & s3_r & ~s2_r;
        end
    endgenerate
endmodule // ecp_edge_sync
`default_nettype wire

// ==== logic/ecp_map.vh ====
// Register offsets, field positions and reset values of the external control port.
`ifndef ECP_MAP_VH
`define ECP_MAP_VH

`define ECP_OFF_CTRL      12'h000
`define ECP_OFF_STATUS    12'h004
`define ECP_OFF_IRQ_STAT  12'h008
`define ECP_OFF_IRQ_EN    12'h00c
`define ECP_OFF_IRQ_CLR   12'h010
`define ECP_OFF_STATE     12'h014

`define ECP_CTRL_EXT_EN   0
`define ECP_CTRL_PWR_ON   1
`define ECP_CTRL_BUSY     2
`define ECP_CTRL_RESET    32'h0000_0000

`define ECP_ST_PWR        0
`define ECP_ST_OUT        1
`define ECP_ST_LIM        2
`define ECP_ST_BUSY       3
`define ECP_ST_SEQ_LO     4
`define ECP_ST_SEQ_HI     5
`define ECP_ST_BR_LO      6
`define ECP_ST_BR_HI      7

`define ECP_NCMD          7
`define ECP_CMD_OFF       0
`define ECP_CMD_ON        1
`define ECP_CMD_START     2
`define ECP_CMD_STOP      3
`define ECP_CMD_HOLD      4
`define ECP_CMD_BR1       5
`define ECP_CMD_BR2       6

`define ECP_SEQ_IDLE      2'h0
`define ECP_SEQ_RUN       2'h1
`define ECP_SEQ_HOLD      2'h2

`endif

// ==== logic/ecp_port.v ====
// External control I/O port with AHB-Lite register access.
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_map.vh"
// Operation
// - The power-state pin is high while the source is on and low while it is off.
// - The output-state pin is high while the power output is enabled, low otherwise.
// - The limiter pin is high while any of the four limiters is active, low otherwise.
// - The busy pin is high while firmware is busy and low when idle.
// - A falling edge on the output-off input turns the output off; levels do nothing.
// - A falling edge on the output-on input turns the output on; only that edge counts.
// - A falling edge on the sequence-start input starts the programmed sequence.
// - A falling edge on the sequence-stop input ends the running sequence.
// - A falling edge on the sequence-hold input pauses the running sequence.
// - A falling edge on the first branch input selects branch one of the running sequence.
// - A falling edge on the second branch input selects branch two of the running sequence.
// - Commands act only while external control is enabled; the controller checks this first.
module ecp_port (
    // AHB-Lite slave
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Limiter conditions
    input  wire        lim_peak_pos,
    input  wire        lim_peak_neg,
    input  wire        lim_avg,
    input  wire        lim_power,
    // Command pins, active on falling edge
    input  wire        output_off_n,
    input  wire        output_on_n,
    input  wire        seq_start_n,
    input  wire        seq_stop_n,
    input  wire        seq_hold_n,
    input  wire        seq_branch1_n,
    input  wire        seq_branch2_n,
    // Status pins
    output wire        power_state_status,
    output wire        output_state_status,
    output wire        limiter_active_status,
    output wire        busy_status,
    // Sequence controls toward the sequencer
    output wire        output_enabled,
    output wire [1:0]  seq_state,
    output wire [1:0]  seq_branch,
    output wire        seq_branch_pulse,
    // Interrupt
    output wire        irq
);
    wire [`ECP_NCMD-1:0] cmd_pulse;
    reg  [31:0] ctrl_r;
    reg         out_on_r;
    reg  [1:0]  seq_r;
    reg  [1:0]  branch_r;
    reg         br_pulse_r;
    reg         pwr_r;
    reg         outs_r;
    reg         lim_r;
    reg         busy_r;
    reg  [7:0]  irq_stat_r;
    reg  [7:0]  irq_en_r;
    reg         wr_pend_r;
    reg         rd_pend_r;
    reg  [11:0] addr_r;
    reg  [31:0] rdata_r;
    reg  [31:0] rdata_nxt;
    reg  [1:0]  seq_nxt;
    wire        ext_en;
    wire        lim_any;
    wire        access;
    wire [7:0]  events;
    wire [7:0]  irq_clr;

    assign ext_en  = ctrl_r[`ECP_CTRL_EXT_EN];
    assign lim_any = lim_peak_pos | lim_peak_neg | lim_avg | lim_power;
    assign access  = hsel & hready & htrans[1];

    ecp_edge_sync #(
        .N          (`ECP_NCMD)
    ) u_sync (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .cmd_n      ({seq_branch2_n, seq_branch1_n, seq_hold_n, seq_stop_n,
                      seq_start_n, output_on_n, output_off_n}),
        .enable     (ext_en),
        .fall_pulse (cmd_pulse)
    );

    // Sequence next state; stop outranks hold in run and start in hold, and start beats a hold edge in hold.
    always @*
    begin
        seq_nxt = seq_r;
        case (seq_r)
            `ECP_SEQ_IDLE:
            begin
                if (cmd_pulse[`ECP_CMD_START])
                    seq_nxt = `ECP_SEQ_RUN;
            end
            `ECP_SEQ_RUN:
            begin
                if (cmd_pulse[`ECP_CMD_STOP])
                    seq_nxt = `ECP_SEQ_IDLE;
                else if (cmd_pulse[`ECP_CMD_HOLD])
                    seq_nxt = `ECP_SEQ_HOLD;
            end
            `ECP_SEQ_HOLD:
            begin
                if (cmd_pulse[`ECP_CMD_STOP])
                    seq_nxt = `ECP_SEQ_IDLE;
                else if (cmd_pulse[`ECP_CMD_START])
                    seq_nxt = `ECP_SEQ_RUN;
            end
            default:
                seq_nxt = `ECP_SEQ_IDLE;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_on_r   <= 1'b0;
            seq_r      <= `ECP_SEQ_IDLE;
            branch_r   <= 2'h0;
            br_pulse_r <= 1'b0;
        end
        else
        begin
            // Off wins if both edges land together, the safe choice for a power stage.
            if (cmd_pulse[`ECP_CMD_OFF])
                out_on_r <= 1'b0;
            else if (cmd_pulse[`ECP_CMD_ON])
                out_on_r <= 1'b1;
            seq_r      <= seq_nxt;
            br_pulse_r <= 1'b0;
            if (seq_r == `ECP_SEQ_RUN && cmd_pulse[`ECP_CMD_BR1])
            begin
                branch_r   <= 2'h1;
                br_pulse_r <= 1'b1;
            end
            else if (seq_r == `ECP_SEQ_RUN && cmd_pulse[`ECP_CMD_BR2])
            begin
                branch_r   <= 2'h2;
                br_pulse_r <= 1'b1;
            end
        end
    end

    // Status pins are registered so they never glitch on the connector.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwr_r  <= 1'b0;
            outs_r <= 1'b0;
            lim_r  <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            pwr_r  <= ctrl_r[`ECP_CTRL_PWR_ON];
            outs_r <= out_on_r;
            lim_r  <= lim_any;
            busy_r <= ctrl_r[`ECP_CTRL_BUSY];
        end
    end

    assign events  = {br_pulse_r & (branch_r == 2'h2), br_pulse_r & (branch_r == 2'h1),
                      cmd_pulse[`ECP_CMD_HOLD], cmd_pulse[`ECP_CMD_STOP], cmd_pulse[`ECP_CMD_START],
                      cmd_pulse[`ECP_CMD_ON], cmd_pulse[`ECP_CMD_OFF], lim_any & ~lim_r};
    assign irq_clr = (wr_pend_r && addr_r == `ECP_OFF_IRQ_CLR) ? hwdata[7:0] : 8'h00;

    // AHB data phase; writes complete with zero wait states.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r  <= 1'b0;
            rd_pend_r  <= 1'b0;
            addr_r     <= 12'h000;
            ctrl_r     <= `ECP_CTRL_RESET;
            irq_en_r   <= 8'h00;
            irq_stat_r <= 8'h00;
            rdata_r    <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= access & hwrite;
            rd_pend_r <= access & ~hwrite;
            if (access)
                addr_r <= haddr;
            if (access & ~hwrite)
                rdata_r <= rdata_nxt;
            if (wr_pend_r && addr_r == `ECP_OFF_CTRL)
                ctrl_r <= {29'h0000_0000, hwdata[2:0]};
            if (wr_pend_r && addr_r == `ECP_OFF_IRQ_EN)
                irq_en_r <= hwdata[7:0];
            // A new event beats a clear in the same cycle.
            irq_stat_r <= (irq_stat_r & ~irq_clr) | events;
        end
    end

    always @*
    begin
        case (haddr)
            `ECP_OFF_CTRL:     rdata_nxt = ctrl_r;
            `ECP_OFF_STATUS:   rdata_nxt = {24'h00_0000, branch_r, seq_r, busy_r, lim_r, outs_r, pwr_r};
            `ECP_OFF_IRQ_STAT: rdata_nxt = {24'h00_0000, irq_stat_r};
            `ECP_OFF_IRQ_EN:   rdata_nxt = {24'h00_0000, irq_en_r};
            `ECP_OFF_STATE:    rdata_nxt = {31'h0000_0000, ext_en};
            default:           rdata_nxt = 32'h0000_0000;
        endcase
    end

    assign hrdata    = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign power_state_status    = pwr_r;
    assign output_state_status   = outs_r;
    assign limiter_active_status = lim_r;
    assign busy_status           = busy_r;
    assign output_enabled        = out_on_r;
    assign seq_state             = seq_r;
    assign seq_branch            = branch_r;
    assign seq_branch_pulse      = br_pulse_r;
    assign irq                   = |(irq_stat_r & irq_en_r);
endmodule // ecp_port
`default_nettype wire

// ==== tb/ecp_ctrl_model.sv ====
// External controller model driving the active-low command pins.
`timescale 1ns/1ps
`default_nettype none
module ecp_ctrl_model (
    // Clock
    input wire logic       hclk,
    // Command pins, idle high as the pull-ups leave them
    output var logic [6:0] cmd_n
);
    initial cmd_n = 7'h7f;
    // Low for two samples and high well after, so no edge can merge with the next.
    task automatic pulse(input int idx);
        @(posedge hclk);
        cmd_n[idx] <= 1'b0;
        repeat (2) @(posedge hclk);
        cmd_n[idx] <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask
endmodule // ecp_ctrl_model
`default_nettype wire

// ==== tb/ecp_port_properties.sv ====
// Checker for the external control port pins.
`timescale 1ns/1ps
`default_nettype none
module ecp_port_properties (
    // Clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // Bus response
    input wire logic       hreadyout,
    input wire logic       hresp,
    // Limiters
    input wire logic       lim_peak_pos,
    input wire logic       lim_peak_neg,
    input wire logic       lim_avg,
    input wire logic       lim_power,
    // Commands
    input wire logic       output_off_n,
    input wire logic       output_on_n,
    input wire logic       seq_start_n,
    input wire logic       seq_stop_n,
    input wire logic       seq_hold_n,
    // Status and state
    input wire logic       output_enabled,
    input wire logic       output_state_status,
    input wire logic       limiter_active_status,
    input wire logic [1:0] seq_state,
    input wire logic       seq_branch_pulse
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    lim_status_a: assert property (
        limiter_active_status == $past(lim_peak_pos | lim_peak_neg | lim_avg | lim_power))
        else $error("limiter status wrong");
    out_status_a: assert property (output_state_status == $past(output_enabled))
        else $error("output status wrong");
    out_on_a: assert property (
        $rose(output_enabled) |-> !$past(output_on_n, 3) || !$past(output_on_n, 4))
        else $error("output on without edge");
    out_off_a: assert property (
        $fell(output_enabled) |-> !$past(output_off_n, 3) || !$past(output_off_n, 4))
        else $error("output off without edge");
    seq_run_a: assert property (
        $changed(seq_state) && seq_state == 2'h1 |-> !$past(seq_start_n, 3) || !$past(seq_start_n, 4))
        else $error("run without start");
    seq_hold_a: assert property (
        $changed(seq_state) && seq_state == 2'h2 |-> !$past(seq_hold_n, 3) || !$past(seq_hold_n, 4))
        else $error("hold without edge");
    seq_stop_a: assert property (
        $changed(seq_state) && seq_state == 2'h0 |-> !$past(seq_stop_n, 3) || !$past(seq_stop_n, 4))
        else $error("stop without edge");
    branch_pulse_a: assert property (
        seq_branch_pulse |-> $past(seq_state) == 2'h1 ##1 !seq_branch_pulse)
        else $error("branch pulse wrong");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus response wrong");
endmodule // ecp_port_properties
bind ecp_port ecp_port_properties i_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .lim_peak_pos(lim_peak_pos), .lim_peak_neg(lim_peak_neg), .lim_avg(lim_avg),
    .lim_power(lim_power), .output_off_n(output_off_n), .output_on_n(output_on_n),
    .seq_start_n(seq_start_n), .seq_stop_n(seq_stop_n), .seq_hold_n(seq_hold_n),
    .output_enabled(output_enabled), .output_state_status(output_state_status),
    .limiter_active_status(limiter_active_status), .seq_state(seq_state),
    .seq_branch_pulse(seq_branch_pulse));
`default_nettype wire

// ==== tb/external_control_io_port_tb_top.sv ====
// Testbench for the external control port.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_map.vh"
module external_control_io_port_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0]  lim = 4'h0;
    logic [6:0]  cmd_n;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, irq, pwr_s, out_s, lim_s, busy_s, out_en, br_p;
    logic [1:0]  seq_st, seq_br;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          br_cnt = 0;

    always #50 hclk = ~hclk;

    // The branch pulse stands for one cycle only, so it is counted as it goes by.
    always @(posedge hclk)
        if (br_p === 1'b1)
            br_cnt++;

    ecp_ctrl_model i_ctrl (.hclk(hclk), .cmd_n(cmd_n));
    ecp_port i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lim_peak_pos(lim[0]), .lim_peak_neg(lim[1]),
        .lim_avg(lim[2]), .lim_power(lim[3]), .output_off_n(cmd_n[0]), .output_on_n(cmd_n[1]),
        .seq_start_n(cmd_n[2]), .seq_stop_n(cmd_n[3]), .seq_hold_n(cmd_n[4]),
        .seq_branch1_n(cmd_n[5]), .seq_branch2_n(cmd_n[6]), .power_state_status(pwr_s),
        .output_state_status(out_s), .limiter_active_status(lim_s), .busy_status(busy_s),
        .output_enabled(out_en), .seq_state(seq_st), .seq_branch(seq_br),
        .seq_branch_pulse(br_p), .irq(irq));

    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic step;
        repeat (2) @(posedge hclk);
    endtask

    task automatic cmd(input int i);
        i_ctrl.pulse(i);
        step;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        cmd(1);
        chk(out_en, 1'b0);
        ahb(`ECP_OFF_IRQ_EN, 1'b1, 32'h4);
        ahb(`ECP_OFF_CTRL, 1'b1, 32'h7);
        step;
        chk({pwr_s, busy_s}, 2'h3);
        $display("test enable done");
        cmd(1);
        chk({out_en, out_s, irq}, 3'h7);
        ahb(`ECP_OFF_IRQ_STAT, 1'b0, 32'h0);
        chk(rd, 32'h4);
        ahb(`ECP_OFF_IRQ_CLR, 1'b1, 32'h4);
        step;
        chk(irq, 1'b0);
        cmd(0);
        chk({out_en, out_s}, 2'h0);
        ahb(`ECP_OFF_CTRL, 1'b1, 32'h1);
        step;
        chk({pwr_s, busy_s}, 2'h0);
        $display("test output done");
        for (int i = 0; i < 4; i++)
        begin
            lim <= 4'h1 << i;
            step;
            chk(lim_s, 1'b1);
        end
        lim <= 4'h0;
        step;
        chk(lim_s, 1'b0);
        $display("test limiter done");
        cmd(2);
        chk(seq_st, `ECP_SEQ_RUN);
        cmd(5);
        chk(seq_br, 2'h1);
        cmd(6);
        chk(seq_br, 2'h2);
        cmd(4);
        chk(seq_st, `ECP_SEQ_HOLD);
        cmd(5);
        chk(seq_br, 2'h2);
        cmd(3);
        chk(seq_st, `ECP_SEQ_IDLE);
        chk(br_cnt, 32'h2);
        ahb(`ECP_OFF_IRQ_STAT, 1'b0, 32'h0);
        chk(rd, 32'hfb);
        ahb(12'h040, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test sequence done");
        give_verdict;
    end

    // The tests need well under a thousand cycles; four thousand means a hang.
    initial
    begin
        #400000;
        num_errors++;
        give_verdict;
    end
endmodule // external_control_io_port_tb_top
`default_nettype wire
